/* rtl/icd_params.svh */
// constants for the input clock divider and phase control block
`ifndef ICD_PARAMS_SVH
`define ICD_PARAMS_SVH

// ------------------------------------------------------------
// register indices; byte address is four times the index
// ------------------------------------------------------------
`define ICD_IDX_RATIO 10'h108
`define ICD_IDX_LOCAL 10'h109
`define ICD_IDX_SYNC 10'h10A
`define ICD_IDX_SREF 10'h120
`define ICD_IDX_CAPT 10'h129

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ICD_RATIO_MSB 2
`define ICD_OFS_MSB 3
`define ICD_AUTO_BIT 7
`define ICD_NEG_MSB 3
`define ICD_NEG_LSB 2
`define ICD_POS_MSB 1
`define ICD_POS_LSB 0
`define ICD_SREF_MSB 2
`define ICD_SREF_LSB 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ICD_RST_RATIO 3'h0
`define ICD_RST_OFS 4'h0
`define ICD_RST_AUTO 1'h0
`define ICD_RST_WIN 2'h0
`define ICD_RST_SREF 2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ICD_DELAY_STAGES 8

`endif

/* rtl/icd_pkg.sv */
// types shared by the clock divider phase control block
package icd_pkg;

    // divider phase count and phase offset in half cycles
    typedef logic [1:0] icd_cnt_t;
    typedef logic [3:0] icd_ofs_t;

    // documented ratio codes
    typedef enum logic [1:0] {
        ICD_DIV1 = 2'b00,
        ICD_DIV2 = 2'b01,
        ICD_DIV4 = 2'b11
    } icd_ratio_t;

    // register selected by a bus address
    typedef enum logic [2:0] {
        ICD_SEL_NONE = 3'b000,
        ICD_SEL_RATIO = 3'b001,
        ICD_SEL_LOCAL = 3'b010,
        ICD_SEL_SYNC = 3'b011,
        ICD_SEL_SREF = 3'b100,
        ICD_SEL_CAPT = 3'b101
    } icd_sel_t;

endpackage

/* rtl/icd_delay_line.sv */
// tapped delay line that retards the divider phase by whole cycles
`timescale 1ns/100ps
`include "icd_params.svh"

module icd_delay_line (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // phase in, tap select, delayed phase out
    input wire icd_pkg::icd_cnt_t cnt_in,
    input wire logic [2:0] tap_sel,
    output icd_pkg::icd_cnt_t cnt_out
);
    import icd_pkg::*;

    icd_cnt_t stage [0:`ICD_DELAY_STAGES-1];
    icd_cnt_t next_stage [0:`ICD_DELAY_STAGES-1];

    // ------------------------------------------------------------
    // stages: stage i holds the phase i+1 cycles old
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `ICD_DELAY_STAGES; gi = gi + 1) begin : g_stage
            if (gi == 0) begin : g_first
                always_comb begin
                    next_stage[gi] = cnt_in;
                end
            end else begin : g_rest
                always_comb begin
                    next_stage[gi] = stage[gi-1];
                end
            end
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stage[gi] <= 2'h0;
                end else begin
                    stage[gi] <= next_stage[gi];
                end
            end
        end
    endgenerate

    // tap 0 is the live phase, so seven whole cycles need seven stages
    always_comb begin
        if (tap_sel == 3'h0) begin
            cnt_out = cnt_in;
        end else begin
            cnt_out = stage[tap_sel - 3'h1];
        end
    end

endmodule

/* rtl/icd_top.sv */
// input clock divider with local phase offset and SYSREF realignment
`timescale 1ns/100ps
`include "icd_params.svh"

module icd_top (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // timing reference
    input wire logic sysref,
    // divided clock view
    output logic div_tick,
    output icd_pkg::icd_cnt_t div_phase,
    output logic half_invert
);
    import icd_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // map a byte address onto a register
    function automatic icd_sel_t reg_decode(input logic [31:0] a);
        icd_sel_t s;
        s = ICD_SEL_NONE;
        if (a == {20'h0, `ICD_IDX_RATIO, 2'b00}) s = ICD_SEL_RATIO;
        if (a == {20'h0, `ICD_IDX_LOCAL, 2'b00}) s = ICD_SEL_LOCAL;
        if (a == {20'h0, `ICD_IDX_SYNC, 2'b00}) s = ICD_SEL_SYNC;
        if (a == {20'h0, `ICD_IDX_SREF, 2'b00}) s = ICD_SEL_SREF;
        if (a == {20'h0, `ICD_IDX_CAPT, 2'b00}) s = ICD_SEL_CAPT;
        return s;
    endfunction

    // last phase count of the divider for a ratio code
    function automatic icd_cnt_t ratio_last(input logic [2:0] code);
        icd_cnt_t l;
        case (code[1:0])
            ICD_DIV1: l = 2'h0;
            ICD_DIV2: l = 2'h1;
            ICD_DIV4: l = 2'h3;
            default: l = 2'h0; // undocumented code runs undivided
        endcase
        return l;
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [2:0] ratio, next_ratio;
    icd_ofs_t local_ofs, next_local_ofs;
    logic auto_en, next_auto_en;
    logic [1:0] neg_win, next_neg_win;
    logic [1:0] pos_win, next_pos_win;
    logic [1:0] sref_mode, next_sref_mode;
    icd_ofs_t capt_ofs, next_capt_ofs;

    // bus pipeline state
    logic wr_pend, next_wr_pend;
    icd_sel_t wr_sel, next_wr_sel;
    logic [31:0] next_hrdata;
    logic addr_ok;
    icd_sel_t addr_sel;

    // divider state
    icd_cnt_t cnt, next_cnt;
    logic sysref_q;
    icd_cnt_t tap_cnt;
    icd_ofs_t eff_ofs;
    logic sref_rise;
    logic sref_take;
    icd_ofs_t cap_half;
    icd_ofs_t period;
    icd_ofs_t rel_half;
    logic in_window;
    logic next_div_tick;
    icd_cnt_t next_div_phase;
    logic next_half_invert;

    // address phase is taken only on a real transfer with hready high
    always_comb begin
        addr_ok = hsel & htrans[1] & hready;
        addr_sel = reg_decode(haddr);
    end

    // write data lands in the data phase after the address phase
    always_comb begin
        next_wr_pend = addr_ok & hwrite;
        next_wr_sel = addr_ok ? addr_sel : ICD_SEL_NONE;
        next_ratio = ratio;
        next_local_ofs = local_ofs;
        next_auto_en = auto_en;
        next_neg_win = neg_win;
        next_pos_win = pos_win;
        next_sref_mode = sref_mode;
        if (wr_pend) begin
            case (wr_sel)
                ICD_SEL_RATIO: begin
                    next_ratio = hwdata[`ICD_RATIO_MSB:0];
                end
                ICD_SEL_LOCAL: begin
                    next_local_ofs = hwdata[`ICD_OFS_MSB:0];
                end
                ICD_SEL_SYNC: begin
                    next_auto_en = hwdata[`ICD_AUTO_BIT];
                    next_neg_win = hwdata[`ICD_NEG_MSB:`ICD_NEG_LSB];
                    next_pos_win = hwdata[`ICD_POS_MSB:`ICD_POS_LSB];
                end
                ICD_SEL_SREF: begin
                    next_sref_mode = hwdata[`ICD_SREF_MSB:`ICD_SREF_LSB];
                end
                default: begin
                    // captured phase is read only, unmapped writes drop
                end
            endcase
        end
    end

    // read data built from next values so a read straight after a
    // write to the same register sees the new contents
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (addr_sel)
                ICD_SEL_RATIO: next_hrdata[`ICD_RATIO_MSB:0] = next_ratio;
                ICD_SEL_LOCAL: next_hrdata[`ICD_OFS_MSB:0] = next_local_ofs;
                ICD_SEL_SYNC: begin
                    next_hrdata[`ICD_AUTO_BIT] = next_auto_en;
                    next_hrdata[`ICD_NEG_MSB:`ICD_NEG_LSB] = next_neg_win;
                    next_hrdata[`ICD_POS_MSB:`ICD_POS_LSB] = next_pos_win;
                end
                ICD_SEL_SREF: begin
                    next_hrdata[`ICD_SREF_MSB:`ICD_SREF_LSB] = next_sref_mode;
                end
                ICD_SEL_CAPT: next_hrdata[`ICD_OFS_MSB:0] = next_capt_ofs;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // bus and register flops; zero wait states, always okay
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ratio <= `ICD_RST_RATIO;
            local_ofs <= `ICD_RST_OFS;
            auto_en <= `ICD_RST_AUTO;
            neg_win <= `ICD_RST_WIN;
            pos_win <= `ICD_RST_WIN;
            sref_mode <= `ICD_RST_SREF;
            wr_pend <= 1'b0;
            wr_sel <= ICD_SEL_NONE;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ratio <= next_ratio;
            local_ofs <= next_local_ofs;
            auto_en <= next_auto_en;
            neg_win <= next_neg_win;
            pos_win <= next_pos_win;
            sref_mode <= next_sref_mode;
            wr_pend <= next_wr_pend;
            wr_sel <= next_wr_sel;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // free-running divider and sysref capture
    // ------------------------------------------------------------

    // raw phase counter wraps at the ratio; a shrinking ratio must not
    // leave the count stranded above the new wrap point
    always_comb begin
        if (cnt >= ratio_last(ratio)) begin
            next_cnt = 2'h0;
        end else begin
            next_cnt = cnt + 2'h1;
        end
    end

    // phase seen at the sysref edge, in half cycles, measured against
    // the alignment already in force so repeats of an aligned sysref
    // fall at zero and are swallowed by the windows
    always_comb begin
        sref_rise = sysref & ~sysref_q & (sref_mode != 2'h0);
        cap_half = {1'b0, cnt, 1'b0};
        period = {1'b0, ratio_last(ratio), 1'b0} + 4'h2;
        rel_half = (cap_half - capt_ofs) & (period - 4'h1);
        in_window = (rel_half <= {2'b00, pos_win}) ||
                    ((rel_half + {2'b00, neg_win}) >= period);
        sref_take = auto_en & sref_rise & ~in_window;
    end

    // captured phase only moves on a taken sysref with auto adjust on
    always_comb begin
        if (sref_take) begin
            next_capt_ofs = cap_half;
        end else begin
            next_capt_ofs = capt_ofs;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= 2'h0;
            sysref_q <= 1'b0;
            capt_ofs <= `ICD_RST_OFS;
        end else begin
            cnt <= next_cnt;
            sysref_q <= sysref;
            capt_ofs <= next_capt_ofs;
        end
    end

    // ------------------------------------------------------------
    // phase offset and output
    // ------------------------------------------------------------

    // offset sum wraps at four bits, as the field width does
    always_comb begin
        if (auto_en) begin
            eff_ofs = capt_ofs + local_ofs;
        end else begin
            eff_ofs = local_ofs;
        end
    end

    // whole cycles come from the delay line, the odd half from inversion
    icd_delay_line u_delay (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cnt_in(cnt),
        .tap_sel(eff_ofs[3:1]),
        .cnt_out(tap_cnt)
    );

    always_comb begin
        next_div_phase = tap_cnt;
        next_div_tick = (tap_cnt == 2'h0);
        next_half_invert = eff_ofs[0];
    end

    // outputs trail the tap by one register stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_phase <= 2'h0;
            div_tick <= 1'b0;
            half_invert <= 1'b0;
        end else begin
            div_phase <= next_div_phase;
            div_tick <= next_div_tick;
            half_invert <= next_half_invert;
        end
    end

endmodule

/* bench/icd_checker.sv */
// assertion checker for the clock divider phase block
`timescale 1ns/100ps
module icd_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // divider view
    input wire logic sysref,
    input wire logic div_tick,
    input wire icd_pkg::icd_cnt_t div_phase,
    input wire logic half_invert
);
    logic dp_wr;
    logic dp_rd;
    logic wr_now;
    logic [9:0] dp_idx;
    logic [2:0] ratio;
    logic [3:0] ofs;
    logic [7:0] sync;
    logic [4:0] quiet;
    logic [4:0] quiet_w;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    assign wr_now = dp_wr && hready;
    // register shadows, updated as each write data phase ends
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            ratio <= 3'h0;
            ofs <= 4'h0;
            sync <= 8'h00;
        end else begin
            if (hready) begin
                dp_wr <= hsel && htrans[1] && hwrite;
                dp_rd <= hsel && htrans[1] && !hwrite;
                dp_idx <= haddr[11:2];
            end
            if (wr_now && dp_idx == 10'h108) ratio <= hwdata[2:0];
            if (wr_now && dp_idx == 10'h109) ofs <= hwdata[3:0];
            if (wr_now && dp_idx == 10'h10A) sync <= hwdata[7:0] & 8'h8F;
        end
    end
    // quiet time; the delay line needs up to nine edges to settle
    always_ff @(posedge mclk) begin
        if (sys_rst || wr_now) begin
            quiet <= 5'h00;
            quiet_w <= 5'h00;
        end else begin
            quiet <= sysref ? 5'h00 : quiet + {4'h0, quiet != 5'h1F};
            quiet_w <= quiet_w + {4'h0, quiet_w != 5'h1F};
        end
    end
    div_one_a: assert property (
        quiet == 5'h1F && ratio == 3'h0 |-> div_tick)
        else $error("tick missing at divide by one");
    div_two_a: assert property (
        quiet == 5'h1F && ratio == 3'h1 && div_tick
        |-> $past(div_tick, 2) && !$past(div_tick))
        else $error("divide by two period wrong");
    div_four_a: assert property (
        quiet_w == 5'h1F && ratio == 3'h3 && !sync[7] && div_tick
        |-> $past(div_tick, 4) && !$past(div_tick) && !$past(div_tick, 2)
        && !$past(div_tick, 3))
        else $error("divide by four period wrong");
    tick_phase_a: assert property (
        quiet_w == 5'h1F |-> div_tick == (div_phase == 2'h0)
        && (ratio != 3'h3 || sync[7] || div_phase == $past(div_phase) + 2'h1))
        else $error("tick and phase disagree");
    half_step_a: assert property (
        ofs == $past(ofs) && ofs == $past(ofs, 2) |-> half_invert == ofs[0])
        else $error("half cycle step wrong");
    local_read_a: assert property (
        dp_rd && dp_idx == 10'h109 |-> hrdata == {28'h0, ofs})
        else $error("local offset read wrong");
    sync_read_a: assert property (
        dp_rd && dp_idx == 10'h10A |-> hrdata == {24'h0, sync})
        else $error("sync control read wrong");
    capt_read_a: assert property (
        dp_rd && dp_idx == 10'h129 |-> hrdata[31:4] == 28'h0 && !hrdata[0])
        else $error("captured phase not whole cycles");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule
bind icd_top icd_checker icd_checker_inst (.mclk, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .sysref, .div_tick, .div_phase, .half_invert);

/* bench/icd_sysref_src.sv */
// timing reference source standing at the block's far side
`timescale 1ns/100ps
module icd_sysref_src (
    // clock
    input wire logic mclk,
    // request from the bench
    input wire logic fire,
    // timing reference
    output logic sysref
);
    logic [1:0] hist = 2'h0;
    // two-cycle pulse launched on the device clock, low between pulses
    always @(posedge mclk) begin
        hist <= {hist[0], fire};
    end
    assign sysref = |hist;
endmodule

/* bench/testbench.sv */
// self-checking bench for the clock divider phase block
`timescale 1ns/100ps
module testbench;
    import icd_pkg::*;
    logic mclk, sys_rst, hsel, hwrite, fire, sysref, hreadyout, hresp;
    logic div_tick, half_invert;
    logic [1:0] htrans, k, r0, r1;
    logic [2:0] hsize;
    logic [3:0] a, ofl [4] = '{4'h1, 4'h2, 4'hE, 4'hF};
    logic [31:0] haddr, hwdata, hrdata, rd, cnt;
    icd_cnt_t div_phase;
    int fails, checked, n;
    icd_top icd_top_inst (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .sysref, .div_tick, .div_phase, .half_invert);
    icd_sysref_src icd_sysref_src_inst (.mclk, .fire, .sysref);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // free-running reference count to measure phase against
    always @(posedge mclk) k <= sys_rst ? 2'h0 : k + 2'h1;
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // hready is sampled at the rising edge, as the slave sees it
    task automatic await();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            fails++;
            results();
        end
    endtask
    task automatic xfer(input logic [9:0] idx, input logic wr,
        input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        await();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        await();
        rd = hrdata;
    endtask
    task automatic chk(input logic [9:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        cmp(rd, exp);
    endtask
    // phase of the divided clock relative to the reference count
    task automatic getref(output logic [1:0] r);
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        r = div_phase - k;
    endtask
    task automatic pulse(input logic [1:0] at);
        // k is looked at mid-cycle so every pulse keeps one alignment
        @(negedge mclk);
        for (int j = 0; j < 8 && k !== at; j++) @(negedge mclk);
        if (k !== at) begin
            fails++;
            results();
        end
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        results();
    end
    initial begin
        {hsel, hwrite, fire, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk(10'h109, 32'h0);
        chk(10'h10A, 32'h0);
        xfer(10'h109, 1'b1, 32'hFF);
        chk(10'h109, 32'hF);
        xfer(10'h000, 1'b1, 32'hFF);
        chk(10'h000, 32'h0);
        $display("register test done");
        // ticks in eight cycles for each documented ratio code
        for (int i = 0; i < 3; i++) begin
            xfer(10'h108, 1'b1, (i == 2) ? 32'h3 : i);
            getref(r0);
            cnt = 0;
            repeat (8) @(negedge mclk) cnt += div_tick;
            cmp(cnt, 32'h8 >> i);
        end
        $display("ratio test done");
        xfer(10'h109, 1'b1, 32'h0);
        getref(r0);
        foreach (ofl[i]) begin
            xfer(10'h109, 1'b1, {28'h0, ofl[i]});
            getref(r1);
            cmp({30'h0, r1}, {30'h0, r0 - ofl[i][2:1]});
            cmp({31'h0, half_invert}, {31'h0, ofl[i][0]});
        end
        $display("offset test done");
        xfer(10'h109, 1'b1, 32'h0);
        xfer(10'h120, 1'b1, 32'h6);
        pulse(2'h0);
        chk(10'h129, 32'h0);
        getref(r1);
        cmp({30'h0, r1}, {30'h0, r0});
        xfer(10'h10A, 1'b1, 32'h80);
        pulse(2'h0);
        xfer(10'h129, 1'b0, 32'h0);
        a = rd[3:0];
        getref(r1);
        cmp({30'h0, r1}, {30'h0, r0 - a[2:1]});
        xfer(10'h109, 1'b1, 32'h2);
        getref(r1);
        cmp({30'h0, r1}, {30'h0, r0 - a[2:1] - 2'h1});
        xfer(10'h109, 1'b1, 32'h0);
        pulse(2'h1);
        chk(10'h129, {29'h0, a[2:0] + 3'h2});
        xfer(10'h120, 1'b1, 32'h0);
        xfer(10'h10A, 1'b1, 32'h82);
        xfer(10'h120, 1'b1, 32'h6);
        pulse(2'h2);
        chk(10'h129, {29'h0, a[2:0] + 3'h2});
        pulse(2'h3);
        chk(10'h129, {29'h0, a[2:0] + 3'h6});
        xfer(10'h120, 1'b1, 32'h0);
        xfer(10'h10A, 1'b1, 32'h88);
        chk(10'h10A, 32'h88);
        xfer(10'h120, 1'b1, 32'h6);
        pulse(2'h2);
        chk(10'h129, {29'h0, a[2:0] + 3'h6});
        pulse(2'h0);
        chk(10'h129, {29'h0, a[2:0]});
        xfer(10'h10A, 1'b1, 32'h0);
        pulse(2'h1);
        chk(10'h129, {29'h0, a[2:0]});
        getref(r1);
        cmp({30'h0, r1}, {30'h0, r0});
        $display("sysref test done");
        results();
    end
endmodule
